/* File: include/encoder_pkg.sv */
// Constants and types shared by the encoder position counter control logic
package encoder_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INIT    = 8'h04;
  localparam logic [7:0] OFS_GE      = 8'h08;
  localparam logic [7:0] OFS_POS     = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  // Control register field positions
  localparam int BIT_ENABLE    = 15;
  localparam int BIT_UNIMP_HI  = 14;
  localparam int BIT_IDLE_STOP = 13;
  localparam int MODE_HI       = 12;
  localparam int MODE_LO       = 10;
  localparam int BIT_MATCH_B   = 9;
  localparam int BIT_MATCH_A   = 8;
  localparam int BIT_UNIMP_LO  = 7;

  // Writable control bits: all but bits 14 and 7
  localparam logic [15:0] CONTROL_WMASK = 16'hbf7f;

  // Values after reset
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [31:0] INIT_RESET    = 32'h0000_0000;
  localparam logic [31:0] GE_RESET      = 32'h0000_0000;
  localparam logic [31:0] POS_RESET     = 32'h0000_0000;

  // Status register field positions
  localparam int STAT_DIR     = 0;
  localparam int STAT_ARMED   = 1;
  localparam int STAT_LOADED  = 2;
  localparam int STAT_RUNNING = 3;
  localparam int STAT_PINS_LO = 4;

  // Encoder pin vector positions
  localparam int PIN_A     = 0;
  localparam int PIN_B     = 1;
  localparam int PIN_INDEX = 2;
  localparam int PIN_HOME  = 3;
  localparam int PIN_COUNT = 4;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0]
  {
    MODE_NONE      = 3'b000,
    MODE_IDX_RESET = 3'b001,
    MODE_IDX_LOAD  = 3'b010,
    MODE_HOME_IDX1 = 3'b011,
    MODE_HOME_IDX2 = 3'b100,
    MODE_GE_RESET  = 3'b101,
    MODE_MODULO    = 3'b110,
    MODE_RESERVED  = 3'b111
  } init_mode_t;

  typedef enum logic [2:0]
  {
    HOME_WAIT      = 3'b001,
    HOME_ARMED     = 3'b010,
    HOME_ONE_INDEX = 3'b100
  } home_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Multi-stage synchroniser for asynchronous encoder pins
`timescale 1ns/1ns
module pin_sync
#(
  parameter int WIDTH  = 4,
  parameter int STAGES = 2
)
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg [STAGES];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_reg[i] <= '0;
    end
    else
    begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++)
        stage_reg[i] <= stage_reg[i-1];
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule

/* File: rtl/position_counter_ctrl.sv */
// Quadrature encoder position counter with control register and APB slave
//
// Notes on behaviour
// - The enable bit runs the counters when set and stops them when clear, registers stay usable.
// - The idle-stop bit halts operation while idle mode is asserted, else it keeps running.
// - Bit 14 of the control register is unimplemented and always reads zero.
// - Bits 12 to 10 select the initialization mode and code 111 is reserved.
// - Mode 110 runs the position counter in modulo count mode.
// - Mode 101 resets the counter when it equals the greater-or-equal compare register.
// - Mode 100 loads the initial value on the second index event after a home event.
// - Mode 011 loads the initial value on the first index event after a home event.
// - Mode 010 loads the initial value on the next index event.
// - Mode 001 resets the counter on every index event.
// - Mode 000 makes index events leave the counter alone.
// - An index match needs phase B at the level of the phase B match bit.
// - An index match needs phase A at the level of the phase A match bit, bit 8.
`timescale 1ns/1ns
module position_counter_ctrl
  import encoder_pkg::*;
#(
  parameter int POS_W = 32
)
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             phase_a_input,
  input  wire logic             phase_b_input,
  input  wire logic             index_input,
  input  wire logic             home_input,
  input  wire logic             idle_mode,
  output logic      [POS_W-1:0] position_count,
  output logic                  counting_active
);

  // Register state
  logic [15:0]          control_reg;
  logic [15:0]          control_next;
  logic [POS_W-1:0]     init_reg;
  logic [POS_W-1:0]     ge_reg;
  logic [POS_W-1:0]     pos_reg;
  logic [POS_W-1:0]     pos_next;
  logic [31:0]          prdata_reg;
  logic                 dir_reg;
  logic                 loaded_reg;
  logic                 loaded_next;
  home_state_t          home_reg;
  home_state_t          home_next;
  logic [PIN_COUNT-1:0] pins_prev_reg;

  // Synchronised pins
  logic [PIN_COUNT-1:0] pins_async;
  logic [PIN_COUNT-1:0] pins_sync;

  assign pins_async = {home_input, index_input, phase_b_input, phase_a_input};

  pin_sync
  #(
    .WIDTH  (PIN_COUNT),
    .STAGES (SYNC_STAGES)
  )
  u_pin_sync
  (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // APB decode
  wire access     = psel & penable;
  wire setup      = psel & ~penable;
  wire hit_ctrl   = (paddr == OFS_CONTROL);
  wire hit_init   = (paddr == OFS_INIT);
  wire hit_ge     = (paddr == OFS_GE);
  wire hit_pos    = (paddr == OFS_POS);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_any    = hit_ctrl | hit_init | hit_ge | hit_pos | hit_status;
  wire wr_any     = access & pwrite & hit_any;
  wire wr_ctrl    = wr_any & hit_ctrl;
  wire wr_init    = wr_any & hit_init;
  wire wr_ge      = wr_any & hit_ge;
  wire wr_pos     = wr_any & hit_pos;

  // Control fields
  wire        enable_bit  = control_reg[BIT_ENABLE];
  wire        idle_stop   = control_reg[BIT_IDLE_STOP];
  wire        match_b_val = control_reg[BIT_MATCH_B];
  wire        match_a_val = control_reg[BIT_MATCH_A];
  init_mode_t mode;

  assign mode = init_mode_t'(control_reg[MODE_HI:MODE_LO]);

  // Run gate: enable and not stopped by idle
  wire run = enable_bit & ~(idle_stop & idle_mode);

  // Pin levels and previous levels
  wire a_now     = pins_sync[PIN_A];
  wire b_now     = pins_sync[PIN_B];
  wire idx_now   = pins_sync[PIN_INDEX];
  wire home_now  = pins_sync[PIN_HOME];
  wire a_prev    = pins_prev_reg[PIN_A];
  wire b_prev    = pins_prev_reg[PIN_B];
  wire idx_prev  = pins_prev_reg[PIN_INDEX];
  wire home_prev = pins_prev_reg[PIN_HOME];

  // Quadrature decode, one count per valid edge
  wire a_moved = a_now ^ a_prev;
  wire b_moved = b_now ^ b_prev;
  wire step    = run & (a_moved ^ b_moved);
  wire step_up = a_now ^ b_prev;

  // Index match qualified by phase levels
  wire phase_b_ok  = (b_now == match_b_val);
  wire phase_a_ok  = (a_now == match_a_val);
  wire index_event = run & idx_now & ~idx_prev & phase_a_ok & phase_b_ok;
  wire home_event  = run & home_now & ~home_prev;

  // Mode decode
  wire mode_idx_reset = (mode == MODE_IDX_RESET);
  wire mode_idx_load  = (mode == MODE_IDX_LOAD);
  wire mode_home1     = (mode == MODE_HOME_IDX1);
  wire mode_home2     = (mode == MODE_HOME_IDX2);
  wire mode_ge_reset  = (mode == MODE_GE_RESET);
  wire mode_modulo    = (mode == MODE_MODULO);
  wire mode_homed     = mode_home1 | mode_home2;

  // Counter arithmetic
  wire [POS_W-1:0] pos_plus  = pos_reg + POS_W'(1);
  wire [POS_W-1:0] pos_minus = pos_reg - POS_W'(1);
  wire             at_ge     = (pos_reg == ge_reg);
  wire             at_init   = (pos_reg == init_reg);

  // Index-driven actions
  wire idx_zero  = mode_idx_reset & index_event;
  wire idx_load1 = mode_idx_load & index_event & ~loaded_reg;
  logic home_load;

  // Home-qualified sequencing
  always_comb
  begin
    home_next = home_reg;
    home_load = 1'b0;
    unique case (home_reg)
      HOME_WAIT:
      begin
        if (home_event)
          home_next = HOME_ARMED;
      end
      HOME_ARMED:
      begin
        if (index_event && mode_home1)
        begin
          home_load = 1'b1;
          home_next = HOME_WAIT;
        end
        else if (index_event)
          home_next = HOME_ONE_INDEX;
      end
      HOME_ONE_INDEX:
      begin
        if (index_event)
        begin
          home_load = 1'b1;
          home_next = HOME_WAIT;
        end
      end
      default:
      begin
        home_next = HOME_WAIT;
      end
    endcase
    if (!mode_homed || wr_ctrl)
    begin
      home_next = HOME_WAIT;
      home_load = 1'b0;
    end
  end

  // One-shot flag for next-index load
  always_comb
  begin
    loaded_next = loaded_reg;
    if (idx_load1)
      loaded_next = 1'b1;
    if (wr_ctrl)
      loaded_next = 1'b0;
    if (!mode_idx_load)
      loaded_next = 1'b0;
  end

  // Position counter next value, later terms win
  always_comb
  begin
    pos_next = pos_reg;
    if (step)
    begin
      if (mode_modulo && step_up && at_ge)
        pos_next = init_reg;
      else if (mode_modulo && !step_up && at_init)
        pos_next = ge_reg;
      else if (step_up)
        pos_next = pos_plus;
      else
        pos_next = pos_minus;
    end
    if (run && mode_ge_reset && at_ge)
      pos_next = POS_RESET[POS_W-1:0];
    if (idx_zero)
      pos_next = POS_RESET[POS_W-1:0];
    if (idx_load1 || home_load)
      pos_next = init_reg;
    if (wr_pos)
      pos_next = pwdata[POS_W-1:0];
  end
  // Mode 000 and the reserved code add no index term

  // Control write keeps unimplemented bits at zero
  assign control_next = pwdata[15:0] & CONTROL_WMASK;

  // Read mux
  wire [31:0] status_word = {24'h00_0000,
                             pins_sync,
                             run,
                             loaded_reg,
                             (home_reg != HOME_WAIT),
                             dir_reg};
  wire [31:0] rd_value =
      hit_ctrl   ? {16'h0000, control_reg} :
      hit_init   ? 32'(init_reg) :
      hit_ge     ? 32'(ge_reg) :
      hit_pos    ? 32'(pos_reg) :
      hit_status ? status_word :
                   32'h0000_0000;

  // Control register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      control_reg <= CONTROL_RESET;
    else if (wr_ctrl)
      control_reg <= control_next;
  end

  // Initial value and compare registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      init_reg <= INIT_RESET[POS_W-1:0];
      ge_reg   <= GE_RESET[POS_W-1:0];
    end
    else
    begin
      if (wr_init)
        init_reg <= pwdata[POS_W-1:0];
      if (wr_ge)
        ge_reg <= pwdata[POS_W-1:0];
    end
  end

  // Position counter and direction
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_reg <= POS_RESET[POS_W-1:0];
      dir_reg <= 1'b0;
    end
    else
    begin
      pos_reg <= pos_next;
      if (step)
        dir_reg <= step_up;
    end
  end

  // Sequencing state
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      home_reg   <= HOME_WAIT;
      loaded_reg <= 1'b0;
    end
    else
    begin
      home_reg   <= home_next;
      loaded_reg <= loaded_next;
    end
  end

  // Previous pin levels for edge detection
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pins_prev_reg <= '0;
    else
      pins_prev_reg <= pins_sync;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      prdata_reg <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_reg <= rd_value;
  end

  assign prdata          = prdata_reg;
  assign pready          = 1'b1;
  assign pslverr         = access & ~hit_any;
  assign position_count  = pos_reg;
  assign counting_active = run;

endmodule

/* File: dv/position_counter_ctrl_checker.sv */
// Concurrent checks on the position counter control ports
`timescale 1ns/1ns
module position_counter_ctrl_checker
  import encoder_pkg::*;
#(
  parameter int POS_W = 32
)
(
  input wire logic             clk_sys,
  input wire logic             arst_n,
  input wire logic [7:0]       paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             phase_a_input,
  input wire logic             phase_b_input,
  input wire logic             index_input,
  input wire logic             idle_mode,
  input wire logic [POS_W-1:0] position_count,
  input wire logic             counting_active
);
  import encoder_pkg::*;
  logic [15:0] ctl_reg;
  logic [31:0] ge_reg;
  logic [2:0]  s1_reg;
  logic [2:0]  s2_reg;
  logic        s3_reg;
  wire         acc    = psel && penable;
  wire         pos_wr = acc && pwrite && paddr == OFS_POS;
  wire         unmap  = paddr > OFS_STATUS || paddr[1:0] != 2'h0;
  wire  [2:0]  mode   = ctl_reg[MODE_HI:MODE_LO];
  // Own copy of the pin synchroniser and control shadow
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      ctl_reg <= '0;
      ge_reg  <= '0;
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= 1'b0;
    end
    else
    begin
      if (acc && pwrite && paddr == OFS_CONTROL)
        ctl_reg <= pwdata[15:0] & CONTROL_WMASK;
      if (acc && pwrite && paddr == OFS_GE)
        ge_reg <= pwdata;
      s1_reg <= {index_input, phase_b_input, phase_a_input};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg[2];
    end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence idx_s;
    s2_reg[2] && !s3_reg && s2_reg[0] == ctl_reg[BIT_MATCH_A]
      && s2_reg[1] == ctl_reg[BIT_MATCH_B] && counting_active;
  endsequence
  sequence rd_s;
    acc && !pwrite && paddr == OFS_CONTROL;
  endsequence
  active_state_a: assert property (counting_active == (ctl_reg[BIT_ENABLE]
    && !(ctl_reg[BIT_IDLE_STOP] && idle_mode))) else $error("active flag wrong");
  count_frozen_a: assert property (!counting_active && !pos_wr |=> $stable(position_count))
    else $error("counter moved while stopped");
  control_read_a: assert property (rd_s |-> prdata == {16'h0, ctl_reg})
    else $error("control readback wrong");
  unmapped_err_a: assert property (acc |-> pslverr == unmap)
    else $error("pslverr wrong");
  zero_wait_a: assert property (acc |-> pready)
    else $error("pready low in access");
  index_reset_a: assert property (idx_s ##0 (mode == 3'h1 && !pos_wr)
    |-> ##[1:2] position_count == '0) else $error("index reset missed");
  ge_reset_a: assert property (mode == 3'h5 && counting_active && !pos_wr
    && position_count == ge_reg[POS_W-1:0] |=> position_count == '0) else $error("ge reset missed");
  reset_state_a: assert property ($rose(arst_n) |-> position_count == '0 && !counting_active)
    else $error("state after reset wrong");
endmodule
bind position_counter_ctrl position_counter_ctrl_checker #(.POS_W(POS_W)) chk (.clk_sys, .arst_n,
  .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .phase_a_input,
  .phase_b_input, .index_input, .idle_mode, .position_count, .counting_active);

/* File: dv/encoder_model.sv */
// Behavioural incremental encoder with index and home outputs
`timescale 1ns/1ns
module encoder_model
(
  input  wire logic clk_sys,
  input  wire logic step,
  input  wire logic up,
  input  wire logic index_req,
  input  wire logic home_req,
  output logic      phase_a,
  output logic      phase_b,
  output logic      index_out,
  output logic      home_out
);
  logic [1:0] q_reg = 2'h0;
  // Forward order 00, 10, 11, 01 on A and B
  assign phase_a = q_reg == 2'h1 || q_reg == 2'h2;
  assign phase_b = q_reg[1];
  always @(posedge clk_sys)
  begin
    if (step)
      q_reg <= up ? q_reg + 2'h1 : q_reg - 2'h1;
    index_out <= index_req;
    home_out  <= home_req;
  end
endmodule

/* File: dv/quadrature_position_counter_ctrl_tb.sv */
// Self-checking bench for the position counter control block
`timescale 1ns/1ns
module quadrature_position_counter_ctrl_tb;
  import encoder_pkg::*;
  localparam int POS_W = 8;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic [7:0]        paddr = 8'h0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pa;
  logic              pb;
  logic              idx;
  logic              home;
  logic              idle_mode = 1'b0;
  logic [POS_W-1:0]  position_count;
  logic              counting_active;
  logic              step = 1'b0;
  logic              up = 1'b0;
  logic              index_req = 1'b0;
  logic              home_req = 1'b0;
  logic [31:0]       seed;
  logic [31:0]       rd;
  logic              er;
  int                mismatches = 0;
  int                samples_checked = 0;
  int                ms[4] = '{0, 1, 2, 7};
  always #20 clk_sys = ~clk_sys;
  position_counter_ctrl #(.POS_W(POS_W)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_input(pa),
    .phase_b_input(pb), .index_input(idx), .home_input(home), .idle_mode(idle_mode),
    .position_count(position_count), .counting_active(counting_active));
  encoder_model enc (.clk_sys(clk_sys), .step(step), .up(up), .index_req(index_req),
    .home_req(home_req), .phase_a(pa), .phase_b(pb), .index_out(idx), .home_out(home));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Position after a matched index, starting from 5
  function automatic logic [31:0] exp_idx(input int m, input logic first, input logic [31:0] i);
    if (m == 1)
      return 32'h0;
    if (m == 2 && first)
      return 32'(i[POS_W-1:0]);
    return 32'h5;
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; pready !== 1'b1 && n < 20; n++)
      @(posedge clk_sys);
    if (n >= 20)
    begin
      mismatches++;
      $display("Error t=%0t no pready", $time);
      close_out;
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Each quadrature state is held six cycles
  task move(input int n, input logic u);
    repeat (n)
    begin
      @(posedge clk_sys);
      step <= 1'b1;
      up   <= u;
      @(posedge clk_sys);
      step <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task pulse(input logic h);
    @(posedge clk_sys);
    index_req <= !h;
    home_req  <= h;
    repeat (4) @(posedge clk_sys);
    index_req <= 1'b0;
    home_req  <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
  initial
  begin
    seed = 32'h1b;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdchk(OFS_CONTROL, 32'h0);
    rdchk(OFS_POS, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'hffff_ffff);
    rdchk(OFS_CONTROL, {16'h0, CONTROL_WMASK});
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    repeat (4)
    begin
      seed = xs(seed);
      apb(1'b1, OFS_CONTROL, seed);
      rdchk(OFS_CONTROL, {16'h0, seed[15:0] & CONTROL_WMASK});
    end
    $display("test registers done");
    apb(1'b1, OFS_CONTROL, 32'h8000);
    move(4, 1'b1);
    rdchk(OFS_POS, 32'h4);
    apb(1'b1, OFS_CONTROL, 32'h0);
    move(4, 1'b1);
    rdchk(OFS_POS, 32'h4);
    apb(1'b1, OFS_CONTROL, 32'ha000);
    idle_mode <= 1'b1;
    move(4, 1'b1);
    rdchk(OFS_POS, 32'h4);
    apb(1'b1, OFS_CONTROL, 32'h8000);
    move(4, 1'b0);
    idle_mode <= 1'b0;
    rdchk(OFS_POS, 32'h0);
    $display("test counting done");
    foreach (ms[k])
    begin
      seed = xs(seed);
      apb(1'b1, OFS_INIT, seed);
      apb(1'b1, OFS_POS, 32'h5);
      apb(1'b1, OFS_CONTROL, 32'h8100 | (32'(ms[k]) << 10));
      pulse(1'b0);
      rdchk(OFS_POS, 32'h5);
      apb(1'b1, OFS_CONTROL, 32'h8200 | (32'(ms[k]) << 10));
      pulse(1'b0);
      rdchk(OFS_POS, 32'h5);
      apb(1'b1, OFS_CONTROL, 32'h8000 | (32'(ms[k]) << 10));
      pulse(1'b0);
      rdchk(OFS_POS, exp_idx(ms[k], 1'b1, seed));
      apb(1'b1, OFS_POS, 32'h5);
      pulse(1'b0);
      rdchk(OFS_POS, exp_idx(ms[k], 1'b0, seed));
    end
    for (int m = 3; m < 5; m++)
    begin
      seed = xs(seed);
      apb(1'b1, OFS_INIT, seed);
      apb(1'b1, OFS_POS, 32'h5);
      apb(1'b1, OFS_CONTROL, 32'h8000 | (32'(m) << 10));
      pulse(1'b0);
      rdchk(OFS_POS, 32'h5);
      pulse(1'b1);
      pulse(1'b0);
      rdchk(OFS_POS, (m == 3) ? 32'(seed[POS_W-1:0]) : 32'h5);
      pulse(1'b0);
      rdchk(OFS_POS, 32'(seed[POS_W-1:0]));
    end
    $display("test index done");
    apb(1'b1, OFS_GE, 32'h3);
    apb(1'b1, OFS_INIT, 32'h0);
    apb(1'b1, OFS_POS, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h9400);
    move(3, 1'b1);
    rdchk(OFS_POS, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h9800);
    move(3, 1'b1);
    rdchk(OFS_POS, 32'h3);
    move(1, 1'b1);
    rdchk(OFS_POS, 32'h0);
    $display("test compare done");
    close_out;
  end
endmodule
